/* File: oem_pkg.sv */
// Package of constants for the on-time efficiency measurement block
`default_nettype none
package oem_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] OEM_RESULT_ADDR = 12'h000;
  localparam logic [11:0] OEM_CONTROL_ADDR = 12'h004;
  localparam logic [11:0] OEM_IRQ_STATUS_ADDR = 12'h008;
  localparam logic [11:0] OEM_IRQ_MASK_ADDR = 12'h00c;
  localparam logic [11:0] OEM_PERIOD_ADDR = 12'h010;
  localparam int OEM_ADDR_WIDTH = 12;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int OEM_DONE_BIT = 7;
  localparam int OEM_COUNT_WIDTH = 7;
  localparam int OEM_CIRCUIT_EN_BIT = 0;
  localparam int OEM_START_BIT = 1;
  localparam logic [7:0] OEM_RESULT_RESET = 8'h00;
  localparam logic [1:0] OEM_CONTROL_RESET = 2'h0;
  localparam logic [7:0] OEM_PERIOD_RESET = 8'hff;
  localparam logic [1:0] OEM_IRQ_RESET = 2'h0;
  localparam int OEM_IRQ_DONE_BIT = 0;
  localparam int OEM_IRQ_OVF_BIT = 1;
  // ****************************************
  // AHB encodings
  // ****************************************
  localparam logic [1:0] OEM_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] OEM_HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0] {OEM_IDLE, OEM_WAIT_EDGE, OEM_MEASURE, OEM_DONE} oem_state_type;
endpackage
`default_nettype wire

/* File: oem_sync.sv */
// Two-flop synchroniser for the switch drive pin
`timescale 1ns/1ps
`default_nettype none
module oem_sync
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic stage1_reg;
  logic stage2_reg;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end
    else
    begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_o = stage2_reg;
endmodule
`default_nettype wire

/* File: oem_top.sv */
// On-time efficiency measurement block with AHB-Lite register slave
// Notes on behaviour
// - Count clocks while the high-side switch is on during one switching cycle.
// - Measurement circuitry is powered only while the circuit enable bit is set.
// - Setting the start bit begins one measurement cycle after references.
// - Done flag, bit 7 of result, is set and cleared by hardware only.
// - Done reads 1 after completion, 0 while measurement is incomplete.
// - Whole clock count of the on-time sits in result bits 6 to 0.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module oem_top
  import oem_pkg::*;
#(
  parameter int COUNT_WIDTH = OEM_COUNT_WIDTH
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic high_side_on_i,
  output logic circuit_power_o,
  output logic measure_start_bit_o,
  output logic [7:0] pwm_period_value_o,
  output logic irq_o
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic ap_write_reg, ap_write_next;
  logic [OEM_ADDR_WIDTH-1:0] ap_addr_reg, ap_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] control_reg, control_next;
  logic [7:0] period_reg, period_next;
  logic [1:0] irq_status_reg, irq_status_next;
  logic [1:0] irq_mask_reg, irq_mask_next;
  logic [7:0] result_reg, result_next;
  oem_state_type state_reg, state_next;
  logic drive_on;
  logic drive_prev_reg, drive_prev_next;
  logic take;
  logic status_read;
  logic done_event;
  logic ovf_event;

  assign take = hsel_i && hready_i && (htrans_i == OEM_HTRANS_NONSEQ || htrans_i == OEM_HTRANS_SEQ);

  oem_sync u_sync
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(high_side_on_i),
    .sync_o(drive_on)
  );

  always_comb
  begin
    ap_write_next = take && hwrite_i;
    ap_addr_next = take ? haddr_i[OEM_ADDR_WIDTH-1:0] : ap_addr_reg;
    control_next = control_reg;
    period_next = period_reg;
    irq_mask_next = irq_mask_reg;
    rdata_next = 32'h0000_0000;
    status_read = 1'b0;
    // Write data arrives in the data phase, one cycle after the address
    if (ap_write_reg)
    begin
      unique case (ap_addr_reg)
        OEM_CONTROL_ADDR: control_next = hwdata_i[1:0];
        OEM_IRQ_MASK_ADDR: irq_mask_next = hwdata_i[1:0];
        OEM_PERIOD_ADDR: period_next = hwdata_i[7:0];
        default: control_next = control_reg;
      endcase
    end
    // Read data registered at the address edge so the data phase has no wait
    // A write still in its data phase is forwarded, so back-to-back reads see it
    if (take && !hwrite_i)
    begin
      unique case (haddr_i[OEM_ADDR_WIDTH-1:0])
        OEM_RESULT_ADDR: rdata_next = {24'h00_0000, result_reg};
        OEM_CONTROL_ADDR: rdata_next = {30'h0000_0000, control_next};
        OEM_IRQ_STATUS_ADDR:
        begin
          rdata_next = {30'h0000_0000, irq_status_reg};
          status_read = 1'b1;
        end
        OEM_IRQ_MASK_ADDR: rdata_next = {30'h0000_0000, irq_mask_next};
        OEM_PERIOD_ADDR: rdata_next = {24'h00_0000, period_next};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Measurement engine
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    result_next = result_reg;
    drive_prev_next = drive_on;
    done_event = 1'b0;
    ovf_event = 1'b0;
    if (!control_reg[OEM_CIRCUIT_EN_BIT])
    begin
      // Circuit unpowered: engine parked, last result kept for firmware
      state_next = OEM_IDLE;
    end
    else
    begin
      unique case (state_reg)
        OEM_IDLE:
          if (control_reg[OEM_START_BIT])
          begin
            result_next = OEM_RESULT_RESET;
            state_next = OEM_WAIT_EDGE;
          end
        OEM_WAIT_EDGE:
          // Wait for a fresh rising edge so a partial on-pulse is never counted
          if (drive_on && !drive_prev_reg)
          begin
            result_next = {1'b0, 7'h01};
            state_next = OEM_MEASURE;
          end
        OEM_MEASURE:
          if (!drive_on)
          begin
            result_next[OEM_DONE_BIT] = 1'b1;
            done_event = 1'b1;
            state_next = OEM_DONE;
          end
          else if (result_reg[COUNT_WIDTH-1:0] == {COUNT_WIDTH{1'b1}})
          begin
            // Saturate rather than wrap; flagged as overflow
            ovf_event = 1'b1;
          end
          else
          begin
            result_next[COUNT_WIDTH-1:0] = result_reg[COUNT_WIDTH-1:0] + 7'h01;
          end
        OEM_DONE:
          if (!control_reg[OEM_START_BIT])
          begin
            state_next = OEM_IDLE;
          end
      endcase
    end
    if (state_reg == OEM_IDLE && control_reg[OEM_START_BIT] && control_reg[OEM_CIRCUIT_EN_BIT])
    begin
      result_next[OEM_DONE_BIT] = 1'b0;
    end
  end

  // ****************************************
  // Interrupts: set wins over read-clear
  // ****************************************
  always_comb
  begin
    irq_status_next = status_read ? OEM_IRQ_RESET : irq_status_reg;
    if (done_event)
    begin
      irq_status_next[OEM_IRQ_DONE_BIT] = 1'b1;
    end
    if (ovf_event)
    begin
      irq_status_next[OEM_IRQ_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ap_write_reg <= 1'b0;
      ap_addr_reg <= '0;
      rdata_reg <= 32'h0000_0000;
      control_reg <= OEM_CONTROL_RESET;
      period_reg <= OEM_PERIOD_RESET;
      irq_status_reg <= OEM_IRQ_RESET;
      irq_mask_reg <= OEM_IRQ_RESET;
      result_reg <= OEM_RESULT_RESET;
      state_reg <= OEM_IDLE;
      drive_prev_reg <= 1'b0;
    end
    else
    begin
      ap_write_reg <= ap_write_next;
      ap_addr_reg <= ap_addr_next;
      rdata_reg <= rdata_next;
      control_reg <= control_next;
      period_reg <= period_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      result_reg <= result_next;
      state_reg <= state_next;
      drive_prev_reg <= drive_prev_next;
    end
  end

  assign hrdata_o = rdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign circuit_power_o = control_reg[OEM_CIRCUIT_EN_BIT];
  assign measure_start_bit_o = control_reg[OEM_START_BIT];
  assign pwm_period_value_o = period_reg;
  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_start;
    state_reg == OEM_IDLE && control_reg[OEM_START_BIT] && control_reg[OEM_CIRCUIT_EN_BIT];
  endsequence

  AST_START_CLEARS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    seq_start |=> result_reg == OEM_RESULT_RESET && state_reg == OEM_WAIT_EDGE)
    else $error("Start did not clear result");
  AST_DONE_ON_FALL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == OEM_MEASURE && !drive_on && control_reg[OEM_CIRCUIT_EN_BIT])
    |=> result_reg[OEM_DONE_BIT] && state_reg == OEM_DONE)
    else $error("Done flag missing after on-time end");
  AST_NOT_DONE_MEASURING: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_reg == OEM_MEASURE |-> !result_reg[OEM_DONE_BIT])
    else $error("Done flag set during measurement");
  AST_COUNT_STEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == OEM_MEASURE && drive_on && control_reg[OEM_CIRCUIT_EN_BIT]
     && result_reg[6:0] != 7'h7f)
    |=> result_reg[6:0] == $past(result_reg[6:0]) + 7'h01)
    else $error("Count did not advance");
  AST_POWER_FOLLOWS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !control_reg[OEM_CIRCUIT_EN_BIT] |=> state_reg == OEM_IDLE)
    else $error("Engine ran while unpowered");
  AST_DONE_HW_ONLY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(result_reg[OEM_DONE_BIT]) |-> $past(state_reg) == OEM_MEASURE)
    else $error("Done set outside measurement");
  AST_FIRST_COUNT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state_reg == OEM_WAIT_EDGE && drive_on && !drive_prev_reg && control_reg[OEM_CIRCUIT_EN_BIT])
    |=> result_reg == 8'h01 ##0 state_reg == OEM_MEASURE)
    else $error("Count did not begin at switch turn-on");
  AST_IRQ_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    done_event && irq_mask_reg[OEM_IRQ_DONE_BIT] |=> irq_o)
    else $error("Done interrupt not raised");
endmodule
`default_nettype wire

/* File: oem_hs_drive.sv */
// Behavioural model of the high-side switch gate drive
`timescale 1ns/1ps
`default_nettype none
module oem_hs_drive
(
  input wire logic clock_i,
  input wire logic fire_i,
  input wire logic [7:0] on_len_i,
  output logic high_side_on_o
);
  // ****************************************
  // One on-pulse of on_len_i clocks per fire
  // ****************************************
  logic [7:0] left_reg;
  initial left_reg = 8'h00;
  // Gate idles low between pulses, as a real driver would
  always @(posedge clock_i)
  begin
    if (fire_i)
      left_reg <= on_len_i;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end
  assign high_side_on_o = (left_reg != 8'h00);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench of the on-time efficiency measurement block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  import oem_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, hs_on, power, start, irq, fire = 1'b0;
  logic [7:0] on_len = 8'h00;
  logic [7:0] period;
  int error_cnt = 0;
  int total_checks = 0;
  always #25 clock_i = ~clock_i;
  oem_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .high_side_on_i(hs_on), .circuit_power_o(power), .measure_start_bit_o(start),
    .pwm_period_value_o(period), .irq_o(irq));
  oem_hs_drive u_drive (.clock_i(clock_i), .fire_i(fire), .on_len_i(on_len),
    .high_side_on_o(hs_on));
  // ****************************************
  // Bus tasks, entered just after a rising edge
  // ****************************************
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= OEM_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // One spare edge so register outputs have settled before any compare
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, d, v);
    @(posedge clock_i);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    `CHK(n, e, v)
  endtask
  // Fire one on-pulse, then poll the done flag; the watchdog bounds the poll
  task automatic measure(input logic [7:0] len);
    logic [31:0] v;
    fire <= 1'b1;
    on_len <= len;
    @(posedge clock_i);
    fire <= 1'b0;
    do bus(OEM_RESULT_ADDR, 1'b0, 32'h0, v); while (v[OEM_DONE_BIT] !== 1'b1);
  endtask
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rchk(OEM_RESULT_ADDR, 32'h00, "result reset");
    rchk(OEM_CONTROL_ADDR, 32'h0, "control reset");
    rchk(OEM_IRQ_STATUS_ADDR, 32'h0, "status reset");
    rchk(OEM_PERIOD_ADDR, 32'hff, "period reset");
    `CHK("power off", 1'b0, power)
    `CHK("ready high", 1'b1, hreadyout)
    wr(OEM_PERIOD_ADDR, 32'h31);
    `CHK("period out", 8'h31, period)
    wr(OEM_CONTROL_ADDR, 32'h1);
    `CHK("power on", 1'b1, power)
    // References would be sampled here, start still clear
    `CHK("start clear", 1'b0, start)
    `CHK("start clear low ref", 1'b0, start)
    wr(OEM_IRQ_MASK_ADDR, 32'h1);
    wr(OEM_CONTROL_ADDR, 32'h3);
    rchk(OEM_RESULT_ADDR, 32'h00, "done while pending");
    measure(8'h0a);
    rchk(OEM_RESULT_ADDR, 32'h8a, "ten clocks");
    `CHK("irq raised", 1'b1, irq)
    rchk(OEM_IRQ_STATUS_ADDR, 32'h1, "status done");
    repeat (2) @(posedge clock_i);
    `CHK("irq cleared", 1'b0, irq)
    rchk(OEM_IRQ_STATUS_ADDR, 32'h0, "status after read");
    // Shortened settle wait before the fractional sample; result must hold
    repeat (20) @(posedge clock_i);
    rchk(OEM_RESULT_ADDR, 32'h8a, "held for fraction");
    wr(OEM_CONTROL_ADDR, 32'h1);
    rchk(OEM_RESULT_ADDR, 32'h8a, "result kept");
    wr(OEM_CONTROL_ADDR, 32'h3);
    rchk(OEM_RESULT_ADDR, 32'h00, "restart clears");
    measure(8'h01);
    rchk(OEM_RESULT_ADDR, 32'h81, "one clock");
    // Masked event must not raise the line
    wr(OEM_IRQ_MASK_ADDR, 32'h0);
    wr(OEM_CONTROL_ADDR, 32'h1);
    wr(OEM_CONTROL_ADDR, 32'h3);
    measure(8'h82);
    rchk(OEM_RESULT_ADDR, 32'hff, "saturated count");
    `CHK("irq masked", 1'b0, irq)
    rchk(OEM_IRQ_STATUS_ADDR, 32'h3, "status saturate");
    wr(12'h020, 32'hffffffff);
    rchk(12'h020, 32'h0, "unmapped");
    wr(OEM_RESULT_ADDR, 32'h55);
    rchk(OEM_RESULT_ADDR, 32'hff, "result read only");
    wr(OEM_CONTROL_ADDR, 32'h0);
    `CHK("power parked", 1'b0, power)
    `CHK("okay resp", 1'b0, hresp)
    summarize();
  end
  // A hung poll costs at most 20000 cycles here
  initial
  begin
    #(50 * 20000);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
